// ---- hdl/fiu_pkg.sv ----
// Purpose: Constants and types of the internal fault interrupt unit
// Assumes: One 25 MHz core clock, synchronous active-high reset
// Notes: Commands are one-cycle strobes from the microprogram sequencer
// Contract
// - Enable mask has one bit per source, bits 1 to 10; others unassigned
// - Each hardware event sets its detect bit; detect AND enable feeds encoder
// - Cause code equals source bit number: octal 1-7, 10, 11, 12
// - An encoded enabled event also sets level request bit 14
// - After capture, the detect bit that produced the code is cleared
// - Protect, page fault, illegal opcode are immediate; others wait for instruction end
// - Protect or page fault in a fetch cycle holds the program counter
// - Supply loss wins the encoding when it coincides with another source; before instruction end an immediate source is taken first
// - Nothing is accepted until the interrupt system is switched on
// - Supervisor call writes sign-extended low opcode byte into level 14 T register
// - Protect violation and page fault arise only while paging is on
// - I/O timeout fires when bus answer ready does not come back
// - Parity or nonexistent address captures low 16 address bits
// - Captured cause code is locked until software reads it
// - Interrupt-on enables level switching and lights the lamp
// - Interrupt-off freezes the level and dims the lamp; a switch already started still completes and moves to its target level
// - Reset clears level enable and selects level zero
// - Request and enable registers are readable; write copies the accumulator
// - Masked set and masked clear touch only bits where accumulator is one
// - Highest pending level tracks request AND enable; difference starts a switch
package fiu_pkg;
  localparam int DW = 16;
  localparam int CLK_NS = 40;
  localparam int IO_TMO_NS = 8000;
  localparam int IO_TMO_CYC = IO_TMO_NS / CLK_NS;
  localparam int SRC_SVC = 1;
  localparam int SRC_PROT = 2;
  localparam int SRC_PAGE = 3;
  localparam int SRC_ILL = 4;
  localparam int SRC_ERR = 5;
  localparam int SRC_PRIV = 6;
  localparam int SRC_IOTMO = 7;
  localparam int SRC_PAR = 8;
  localparam int SRC_NXA = 9;
  localparam int SRC_SUP = 10;
  localparam int INT_LVL_BIT = 14;
  localparam logic [15:0] SRC_USED = 16'h07FE;
  localparam logic [15:0] IMM_MASK = 16'h001C;
  localparam logic [3:0] INT_LEVEL = 4'hE;
  localparam logic [3:0] LEVEL_ZERO = 4'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [3:0] RST_CODE = 4'h0;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_READ = 3'b001,
    OP_WRITE = 3'b010,
    OP_MSET = 3'b011,
    OP_MCLR = 3'b100,
    OP_SYS_ON = 3'b101,
    OP_SYS_OFF = 3'b110
  } fiu_op_e;

  typedef enum logic [2:0] {
    SEL_REQ = 3'b000,
    SEL_EN = 3'b001,
    SEL_MASK = 3'b010,
    SEL_CAUSE = 3'b011,
    SEL_FADDR = 3'b100
  } fiu_sel_e;

  typedef enum logic {
    SW_IDLE = 1'b0,
    SW_BUSY = 1'b1
  } fiu_sw_e;

  // Number of highest set bit, zero when none
  function automatic logic [3:0] fiu_top_bit(input logic [15:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction : fiu_top_bit
endpackage : fiu_pkg

// ---- hdl/fiu_prio_if.sv ----
// Purpose: Carries priority vectors between the unit and its encoders
// Assumes: Combinational encoders
// Notes: None
`timescale 1ns/1ps
interface fiu_prio_if;
  logic [15:0] masked;
  logic [3:0] cause;
  logic any;
  logic [15:0] lvl_req;
  logic [15:0] lvl_en;
  logic [3:0] pend;
  modport core (output masked, output lvl_req, output lvl_en,
                input cause, input any, input pend);
  modport cause_side (input masked, output cause, output any);
  modport level_side (input lvl_req, input lvl_en, output pend);
endinterface : fiu_prio_if

// ---- hdl/fiu_cause_enc.sv ----
// Purpose: Priority encoder for masked internal sources
// Assumes: Input already masked
// Notes: Highest bit wins
`timescale 1ns/1ps
module fiu_cause_enc (
  fiu_prio_if.cause_side pif
);
  import fiu_pkg::*;
  // Highest number wins so supply loss beats every other source
  assign pif.cause = fiu_top_bit(pif.masked);
  assign pif.any = |pif.masked;
endmodule : fiu_cause_enc

// ---- hdl/fiu_level_prio.sv ----
// Purpose: Highest pending program level
// Assumes: Combinational
// Notes: Level zero when nothing pending
`timescale 1ns/1ps
module fiu_level_prio (
  fiu_prio_if.level_side pif
);
  import fiu_pkg::*;
  assign pif.pend = fiu_top_bit(pif.lvl_req & pif.lvl_en);
endmodule : fiu_level_prio

// ---- hdl/fiu_unit.sv ----
// Purpose: Internal fault interrupt unit with program level control
// Assumes: Events are one-cycle pulses synchronous to core_clk
// Notes: Context switch microcode is outside; it answers with switch_done
`timescale 1ns/1ps
module fiu_unit #(
  parameter int TMO_CYC = fiu_pkg::IO_TMO_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Special register commands
  input wire logic cmd_valid,
  input wire fiu_pkg::fiu_op_e cmd_op,
  input wire fiu_pkg::fiu_sel_e cmd_sel,
  input wire logic [fiu_pkg::DW-1:0] acc_in,
  output logic [fiu_pkg::DW-1:0] acc_out,
  output logic acc_valid,
  // Fault sources
  input wire logic svc_call,
  input wire logic [7:0] svc_opcode,
  input wire logic protect_violation,
  input wire logic page_fault,
  input wire logic illegal_opcode,
  input wire logic error_flag,
  input wire logic privileged_op_violation,
  input wire logic parity_error,
  input wire logic nonexistent_address,
  input wire logic [23:0] fault_addr,
  input wire logic supply_loss,
  input wire logic paging_on,
  // Bus answer watch
  input wire logic io_start,
  input wire logic bus_answer_ready,
  // Sequencer status
  input wire logic instr_done,
  input wire logic fetch_cycle,
  input wire logic switch_done,
  // Sequencer controls
  output logic micro_trap,
  output logic pc_hold,
  output logic switch_start,
  output logic [3:0] current_level,
  output logic [3:0] highest_pending_level,
  output logic irq_lamp,
  output logic [fiu_pkg::DW-1:0] t14_value,
  output logic t14_wr
);
  import fiu_pkg::*;

  fiu_prio_if pif ();

  // ************************************
  // Storage
  // ************************************
  logic [15:0] detect_r;
  logic [15:0] enable_mask_r;
  logic [15:0] level_request_reg;
  logic [15:0] level_enable_reg;
  logic [3:0] cause_r;
  logic lock_r;
  logic sys_on_r;
  logic [15:0] faulty_addr_low;
  logic [3:0] target_r;
  logic [15:0] tmo_cnt_r;
  logic tmo_run_r;
  fiu_sw_e sw_r;

  logic [15:0] ev_vec;
  logic [15:0] elig;
  logic [15:0] clr_vec;
  logic take;
  logic io_tmo;
  logic cmd_w;
  logic cmd_s;
  logic cmd_c;
  logic rd_cause;

  fiu_cause_enc u_enc (
    .pif(pif.cause_side)
  );

  fiu_level_prio u_lvl (
    .pif(pif.level_side)
  );

  // ************************************
  // Source detection
  // ************************************
  always_comb begin
    ev_vec = 16'h0000;
    ev_vec[SRC_SVC] = svc_call;
    ev_vec[SRC_PROT] = protect_violation & paging_on;
    ev_vec[SRC_PAGE] = page_fault & paging_on;
    ev_vec[SRC_ILL] = illegal_opcode;
    ev_vec[SRC_ERR] = error_flag;
    ev_vec[SRC_PRIV] = privileged_op_violation;
    ev_vec[SRC_IOTMO] = io_tmo;
    ev_vec[SRC_PAR] = parity_error;
    ev_vec[SRC_NXA] = nonexistent_address;
    ev_vec[SRC_SUP] = supply_loss;
  end

  // Immediate sources pass any time, the rest only at instruction end
  assign elig = detect_r & enable_mask_r & SRC_USED & (instr_done ? 16'hFFFF : IMM_MASK);
  assign pif.masked = elig;
  assign pif.lvl_req = level_request_reg;
  assign pif.lvl_en = level_enable_reg;
  assign take = sys_on_r & ~lock_r & pif.any;
  assign clr_vec = take ? (16'h0001 << pif.cause) : 16'h0000;

  assign cmd_w = cmd_valid & (cmd_op == OP_WRITE);
  assign cmd_s = cmd_valid & (cmd_op == OP_MSET);
  assign cmd_c = cmd_valid & (cmd_op == OP_MCLR);
  assign rd_cause = cmd_valid & (cmd_op == OP_READ) & (cmd_sel == SEL_CAUSE);

  // New events win over the capture clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      detect_r <= RST_WORD;
    end else begin
      detect_r <= (detect_r & ~clr_vec) | ev_vec;
    end
  end

  // ************************************
  // Bus answer timeout
  // ************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tmo_run_r <= 1'b0;
      tmo_cnt_r <= 16'h0000;
      io_tmo <= 1'b0;
    end else begin
      io_tmo <= 1'b0;
      if (io_start) begin
        tmo_run_r <= 1'b1;
        tmo_cnt_r <= 16'h0000;
      end else if (tmo_run_r) begin
        if (bus_answer_ready) begin
          tmo_run_r <= 1'b0;
        end else if (tmo_cnt_r == 16'(TMO_CYC - 1)) begin
          tmo_run_r <= 1'b0;
          io_tmo <= 1'b1;
        end else begin
          tmo_cnt_r <= tmo_cnt_r + 16'h0001;
        end
      end
    end
  end

  // ************************************
  // Cause code capture and lock
  // ************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cause_r <= RST_CODE;
      lock_r <= 1'b0;
    end else begin
      if (rd_cause) begin
        cause_r <= RST_CODE;
        lock_r <= 1'b0;
      end
      if (take) begin
        cause_r <= pif.cause;
        lock_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      micro_trap <= 1'b0;
      pc_hold <= 1'b0;
    end else begin
      micro_trap <= take & |(clr_vec & IMM_MASK);
      pc_hold <= fetch_cycle & (ev_vec[SRC_PROT] | ev_vec[SRC_PAGE]);
    end
  end

  // ************************************
  // Special registers
  // ************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      enable_mask_r <= RST_WORD;
    end else if (cmd_valid && cmd_sel == SEL_MASK) begin
      if (cmd_w) begin
        enable_mask_r <= acc_in;
      end else if (cmd_s) begin
        enable_mask_r <= enable_mask_r | acc_in;
      end else if (cmd_c) begin
        enable_mask_r <= enable_mask_r & ~acc_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_enable_reg <= RST_WORD;
    end else if (cmd_valid && cmd_sel == SEL_EN) begin
      if (cmd_w) begin
        level_enable_reg <= acc_in;
      end else if (cmd_s) begin
        level_enable_reg <= level_enable_reg | acc_in;
      end else if (cmd_c) begin
        level_enable_reg <= level_enable_reg & ~acc_in;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      level_request_reg <= RST_WORD;
    end else begin
      if (cmd_valid && cmd_sel == SEL_REQ) begin
        if (cmd_w) begin
          level_request_reg <= acc_in;
        end else if (cmd_s) begin
          level_request_reg <= level_request_reg | acc_in;
        end else if (cmd_c) begin
          level_request_reg <= level_request_reg & ~acc_in;
        end
      end
      if (take) begin
        level_request_reg[INT_LVL_BIT] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      faulty_addr_low <= RST_WORD;
    end else if (parity_error || nonexistent_address) begin
      faulty_addr_low <= fault_addr[15:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      t14_value <= RST_WORD;
      t14_wr <= 1'b0;
    end else begin
      t14_wr <= svc_call;
      if (svc_call) begin
        t14_value <= {{8{svc_opcode[7]}}, svc_opcode};
      end
    end
  end

  // Read port
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      acc_out <= RST_WORD;
      acc_valid <= 1'b0;
    end else begin
      acc_valid <= cmd_valid & (cmd_op == OP_READ);
      if (cmd_valid && cmd_op == OP_READ) begin
        case (cmd_sel)
          SEL_REQ: acc_out <= level_request_reg;
          SEL_EN: acc_out <= level_enable_reg;
          SEL_MASK: acc_out <= enable_mask_r;
          SEL_CAUSE: acc_out <= {12'h000, cause_r};
          SEL_FADDR: acc_out <= faulty_addr_low;
          default: acc_out <= RST_WORD;
        endcase
      end
    end
  end

  // ************************************
  // Interrupt system on and off
  // ************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sys_on_r <= 1'b0;
      irq_lamp <= 1'b0;
    end else if (cmd_valid && cmd_op == OP_SYS_ON) begin
      sys_on_r <= 1'b1;
      irq_lamp <= 1'b1;
    end else if (cmd_valid && cmd_op == OP_SYS_OFF) begin
      sys_on_r <= 1'b0;
      irq_lamp <= 1'b0;
    end
  end

  // ************************************
  // Level switch control
  // ************************************
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sw_r <= SW_IDLE;
      switch_start <= 1'b0;
      target_r <= LEVEL_ZERO;
      current_level <= LEVEL_ZERO;
      highest_pending_level <= LEVEL_ZERO;
    end else begin
      switch_start <= 1'b0;
      highest_pending_level <= pif.pend;
      case (sw_r)
        SW_IDLE: begin
          // Off keeps the current level
          if (sys_on_r && pif.pend != current_level) begin
            sw_r <= SW_BUSY;
            switch_start <= 1'b1;
            target_r <= pif.pend;
          end
        end
        SW_BUSY: begin
          if (switch_done) begin
            current_level <= target_r;
            sw_r <= SW_IDLE;
          end
        end
        default: sw_r <= SW_IDLE;
      endcase
    end
  end

  // ************************************
  // Checks
  // ************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  property p_det_set;
    supply_loss |=> detect_r[SRC_SUP];
  endproperty
  a_det_set: assert property (p_det_set) else $error("supply loss not detected");

  property p_req14;
    take |=> level_request_reg[INT_LVL_BIT] && lock_r;
  endproperty
  a_req14: assert property (p_req14) else $error("level 14 request missing");

  property p_clr_det;
    take && pif.cause == 4'hA && !supply_loss |=> !detect_r[SRC_SUP];
  endproperty
  a_clr_det: assert property (p_clr_det) else $error("detect bit not cleared");

  property p_defer;
    sys_on_r && !lock_r && !instr_done && (detect_r & IMM_MASK) == 16'h0000 |=> !lock_r;
  endproperty
  a_defer: assert property (p_defer) else $error("deferred source taken early");

  property p_sup_win;
    take && elig[SRC_SUP] |=> cause_r == 4'hA;
  endproperty
  a_sup_win: assert property (p_sup_win) else $error("supply loss lost encoding");

  property p_off;
    !sys_on_r && !lock_r |=> !lock_r;
  endproperty
  a_off: assert property (p_off) else $error("capture while system off");

  property p_svc;
    svc_call |=> t14_wr && t14_value == {{8{$past(svc_opcode[7])}}, $past(svc_opcode)};
  endproperty
  a_svc: assert property (p_svc) else $error("T14 value wrong");

  property p_pg_off;
    !paging_on && !detect_r[SRC_PAGE] |=> !detect_r[SRC_PAGE];
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("page fault while paging off");

  property p_faddr;
    parity_error |=> faulty_addr_low == $past(fault_addr[15:0]);
  endproperty
  a_faddr: assert property (p_faddr) else $error("fault address not captured");

  property p_cause_rd;
    rd_cause && !take |=> acc_valid && acc_out[15:4] == 12'h000 && cause_r == 4'h0 && !lock_r;
  endproperty
  a_cause_rd: assert property (p_cause_rd) else $error("cause read wrong");

  property p_lock;
    lock_r && !rd_cause |=> $stable(cause_r);
  endproperty
  a_lock: assert property (p_lock) else $error("locked cause changed");

  property p_lamp;
    cmd_valid && cmd_op == OP_SYS_OFF |=> !irq_lamp ##1 $stable(current_level) || sw_r == SW_IDLE;
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp not off");

  property p_mset;
    cmd_s && cmd_sel == SEL_EN |=> level_enable_reg == ($past(level_enable_reg) | $past(acc_in));
  endproperty
  a_mset: assert property (p_mset) else $error("masked set wrong");

  property p_switch;
    sw_r == SW_IDLE && sys_on_r && pif.pend != current_level |=> switch_start;
  endproperty
  a_switch: assert property (p_switch) else $error("switch not started");

  c_take: cover property (take ##1 micro_trap);
  c_switch: cover property (switch_start ##[1:20] switch_done);
  c_read: cover property (rd_cause && lock_r);
  c_pchold: cover property (pc_hold);
endmodule : fiu_unit

// ---- testbench/fiu_seq_model.sv ----
// Purpose: Stand-in for the sequencer and the addressed bus device
// Assumes: One core clock; answers change on the rising edge
// Notes: slow stretches the switch answer; answer_en low models an absent device
`timescale 1ns/1ps
module fiu_seq_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Switch request from the unit, I/O start and modes from the bench
  input wire logic switch_start,
  input wire logic io_start,
  input wire logic answer_en,
  input wire logic slow,
  // Answers
  output logic switch_done,
  output logic bus_answer_ready
);
  int sw_cnt = 0;
  int io_cnt = 0;
  initial begin
    switch_done = 1'b0;
    bus_answer_ready = 1'b0;
  end
  // ****************************************
  // Context switch microcode, one at a time
  // ****************************************
  always @(posedge core_clk) begin
    switch_done <= 1'b0;
    if (sys_rst) begin
      sw_cnt <= 0;
    end else if (switch_start === 1'b1) begin
      sw_cnt <= slow ? 20 : 2;
    end else if (sw_cnt == 1) begin
      switch_done <= 1'b1;
      sw_cnt <= 0;
    end else if (sw_cnt > 1) begin
      sw_cnt <= sw_cnt - 1;
    end
  end
  // Present device answers three cycles after the start; absent one never
  always @(posedge core_clk) begin
    bus_answer_ready <= 1'b0;
    if (sys_rst) begin
      io_cnt <= 0;
    end else if (io_start === 1'b1 && answer_en) begin
      io_cnt <= 3;
    end else if (io_cnt == 1) begin
      bus_answer_ready <= 1'b1;
      io_cnt <= 0;
    end else if (io_cnt > 1) begin
      io_cnt <= io_cnt - 1;
    end
  end
endmodule : fiu_seq_model

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench of the internal fault interrupt unit
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Bus timeout shortened to 8 cycles
`timescale 1ns/1ps
module tb;
  import fiu_pkg::*;
  localparam int TMO = 8;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  fiu_op_e cmd_op = OP_NONE;
  fiu_sel_e cmd_sel = SEL_REQ;
  logic [15:0] acc_in = 16'h0000;
  logic [10:0] ev = 11'h000;
  logic [7:0] svc_opcode = 8'h85;
  logic [23:0] fault_addr = 24'hABCDEF;
  logic paging_on = 1'b1;
  logic instr_done = 1'b1;
  logic fetch_cycle = 1'b0;
  logic answer_en = 1'b1;
  logic slow = 1'b0;
  logic acc_valid, switch_done, bus_answer_ready, micro_trap;
  logic pc_hold, switch_start, irq_lamp, t14_wr;
  logic [3:0] current_level, highest_pending_level;
  logic [15:0] acc_out, t14_value, t14_seen;
  int n_mismatch = 0;
  int num_checks = 0;
  int n_trap = 0;
  int n_hold = 0;
  int n_cyc = 0;

  always #20 core_clk = ~core_clk;

  fiu_unit #(.TMO_CYC(TMO)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_sel(cmd_sel), .acc_in(acc_in),
    .acc_out(acc_out), .acc_valid(acc_valid), .svc_call(ev[1]), .svc_opcode(svc_opcode),
    .protect_violation(ev[2]), .page_fault(ev[3]), .illegal_opcode(ev[4]),
    .error_flag(ev[5]), .privileged_op_violation(ev[6]), .parity_error(ev[8]),
    .nonexistent_address(ev[9]), .fault_addr(fault_addr), .supply_loss(ev[10]),
    .paging_on(paging_on), .io_start(ev[7]), .bus_answer_ready(bus_answer_ready),
    .instr_done(instr_done), .fetch_cycle(fetch_cycle), .switch_done(switch_done),
    .micro_trap(micro_trap), .pc_hold(pc_hold), .switch_start(switch_start),
    .current_level(current_level), .highest_pending_level(highest_pending_level),
    .irq_lamp(irq_lamp), .t14_value(t14_value), .t14_wr(t14_wr));

  fiu_seq_model seq_u (.core_clk(core_clk), .sys_rst(sys_rst), .switch_start(switch_start),
    .io_start(ev[7]), .answer_en(answer_en), .slow(slow), .switch_done(switch_done),
    .bus_answer_ready(bus_answer_ready));

  // ****************************************
  // Pulse counters and run limit
  // ****************************************
  always @(negedge core_clk) begin
    n_cyc++;
    if (micro_trap === 1'b1) n_trap++;
    if (pc_hold === 1'b1) n_hold++;
    if (t14_wr === 1'b1) t14_seen = t14_value;
    if (n_cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cmd(input fiu_op_e op, input fiu_sel_e sel, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sel = sel;
    acc_in = d;
    @(posedge core_clk);
    #1;
    cmd_valid = 1'b0;
  endtask : cmd

  task automatic rd(input fiu_sel_e sel, input logic [15:0] exp);
    cmd(OP_READ, sel, 16'h0000);
    chk({15'h0000, acc_valid}, 16'h0001);
    chk(acc_out, exp);
  endtask : rd

  task automatic pulse(input logic [10:0] m);
    @(posedge core_clk);
    #1;
    ev = m;
    @(posedge core_clk);
    #1;
    ev = 11'h000;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : pulse

  task automatic wait_level(input logic [3:0] lv);
    int k;
    k = 0;
    while (current_level !== lv && k < 100) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    chk({12'h000, current_level}, {12'h000, lv});
  endtask : wait_level

  task automatic results();
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int s;
    int t;
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    rd(SEL_EN, 16'h0000);
    chk({12'h000, current_level}, 16'h0000);
    cmd(OP_WRITE, SEL_EN, 16'hA5A5);
    cmd(OP_MSET, SEL_EN, 16'h0F00);
    rd(SEL_EN, 16'hAFA5);
    cmd(OP_MCLR, SEL_EN, 16'h8181);
    rd(SEL_EN, 16'h2E24);
    cmd(OP_WRITE, SEL_REQ, 16'h1234);
    rd(SEL_REQ, 16'h1234);
    cmd(OP_WRITE, SEL_REQ, 16'h0000);
    cmd(OP_WRITE, SEL_EN, 16'h0000);
    cmd(OP_WRITE, SEL_MASK, 16'h0FEE);
    cmd(OP_MCLR, SEL_MASK, 16'h0800);
    rd(SEL_MASK, 16'h07EE);
    pulse(11'h010);
    rd(SEL_CAUSE, 16'h0000);
    cmd(OP_SYS_ON, SEL_REQ, 16'h0000);
    chk({15'h0000, irq_lamp}, 16'h0001);
    repeat (3) @(posedge core_clk);
    rd(SEL_CAUSE, 16'h0000);
    cmd(OP_MSET, SEL_MASK, 16'h0010);
    repeat (3) @(posedge core_clk);
    rd(SEL_CAUSE, 16'h0004);
    rd(SEL_CAUSE, 16'h0000);
    rd(SEL_REQ, 16'h4000);
    pulse(11'h080);
    repeat (TMO + 4) @(posedge core_clk);
    rd(SEL_CAUSE, 16'h0000);
    answer_en = 1'b0;
    for (s = 1; s <= 10; s++) begin
      t = n_trap;
      pulse(11'h001 << s);
      if (s == 7) repeat (TMO + 4) @(posedge core_clk);
      rd(SEL_CAUSE, 16'(s));
      chk(16'(n_trap - t), (s >= 2 && s <= 4) ? 16'h0001 : 16'h0000);
    end
    chk(t14_seen, 16'hFF85);
    chk(16'(n_hold), 16'h0000);
    rd(SEL_FADDR, 16'hCDEF);
    svc_opcode = 8'h7F;
    pulse(11'h002);
    chk(t14_seen, 16'h007F);
    rd(SEL_CAUSE, 16'h0001);
    pulse(11'h410);
    rd(SEL_CAUSE, 16'h000A);
    repeat (3) @(posedge core_clk);
    rd(SEL_CAUSE, 16'h0004);
    paging_on = 1'b0;
    pulse(11'h008);
    rd(SEL_CAUSE, 16'h0000);
    paging_on = 1'b1;
    fetch_cycle = 1'b1;
    pulse(11'h004);
    fetch_cycle = 1'b0;
    chk(16'(n_hold), 16'h0001);
    rd(SEL_CAUSE, 16'h0002);
    instr_done = 1'b0;
    pulse(11'h040);
    rd(SEL_CAUSE, 16'h0000);
    instr_done = 1'b1;
    repeat (3) @(posedge core_clk);
    rd(SEL_CAUSE, 16'h0006);
    ev = 11'h020;
    repeat (4) @(posedge core_clk);
    #1;
    rd(SEL_CAUSE, 16'h0005);
    ev = 11'h000;
    rd(SEL_CAUSE, 16'h0005);
    rd(SEL_CAUSE, 16'h0000);
    cmd(OP_SYS_OFF, SEL_REQ, 16'h0000);
    chk({15'h0000, irq_lamp}, 16'h0000);
    cmd(OP_WRITE, SEL_REQ, 16'h4000);
    cmd(OP_WRITE, SEL_EN, 16'h4000);
    repeat (5) @(posedge core_clk);
    chk({12'h000, highest_pending_level}, 16'h000E);
    chk({12'h000, current_level}, 16'h0000);
    cmd(OP_SYS_ON, SEL_REQ, 16'h0000);
    wait_level(4'hE);
    slow = 1'b1;
    cmd(OP_MCLR, SEL_REQ, 16'h4000);
    wait_level(4'h0);
    cmd(OP_MSET, SEL_REQ, 16'h4000);
    wait_level(4'hE);
    cmd(OP_SYS_OFF, SEL_REQ, 16'h0000);
    cmd(OP_MCLR, SEL_REQ, 16'h4000);
    repeat (30) @(posedge core_clk);
    chk({12'h000, current_level}, 16'h000E);
    cmd(OP_SYS_ON, SEL_REQ, 16'h0000);
    wait_level(4'h0);
    results();
  end
endmodule : tb
